/* File: rtl/adcc_pkg.sv */
// Constants for the converter control block.
// Assumes one 25 MHz system clock that is also the converter's oscillator.
package adcc_pkg;
   localparam logic [7:0] OFS_RES_HI   = 8'h1e;
   localparam logic [7:0] OFS_CTRL0    = 8'h1f;
   localparam logic [7:0] OFS_ANS_LO   = 8'h91;
   localparam logic [7:0] OFS_ANS_HI   = 8'h93;
   localparam logic [7:0] OFS_RES_LO   = 8'h9e;
   localparam logic [7:0] OFS_CLK_CTRL = 8'h9f;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'ha0;

   localparam int B_EN      = 0;
   localparam int B_GO      = 1;
   localparam int B_CHS_LO  = 2;
   localparam int B_REF     = 6;
   localparam int B_JUST    = 7;
   localparam int B_CS_LO   = 4;
   localparam int B_FLAG    = 0;
   localparam int B_IE      = 1;
   localparam int B_PE      = 2;

   localparam logic [7:0]  RST_CTRL0    = 8'h00;
   localparam logic [11:0] RST_ANS      = 12'hfff;
   localparam logic [2:0]  RST_CS       = 3'h0;
   localparam logic [2:0]  RST_IRQ      = 3'h0;

   localparam logic [2:0] CS_DIV2  = 3'h0;
   localparam logic [2:0] CS_DIV8  = 3'h1;
   localparam logic [2:0] CS_DIV32 = 3'h2;
   localparam logic [2:0] CS_DIV4  = 3'h4;
   localparam logic [2:0] CS_DIV16 = 3'h5;
   localparam logic [2:0] CS_DIV64 = 3'h6;

   localparam int CLK_NS       = 40;
   localparam int RC_TAD_NS    = 4000;
   localparam int RC_TAD_CYC   = RC_TAD_NS / CLK_NS;
   localparam int INSTR_CYC    = 4;
   localparam int CONV_TADS    = 11;
   localparam int GAP_TADS     = 2;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_CONV  = 4'b0100,
      ST_GAP   = 4'b1000
   } adcc_state_e;
endpackage

/* File: rtl/adcc_ctrl.sv */
// Converter control: registers, bit-period timing, SAR sequencing, pin masks.
// Assumes the analog core drives cmp_in asynchronously; sleep_in is on mclk.
module adcc_ctrl
   import adcc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        sleep_in,
   input  wire logic        cmp_in,
   input  wire logic [11:0] pin_in,
   output logic      [11:0] port_read,
   output logic      [11:0] dig_in_en,
   output logic      [3:0]  channel_select,
   output logic             reference_select,
   output logic             converter_power,
   output logic             sample_en,
   output logic      [9:0]  dac_code,
   output logic             conv_irq,
   output logic             wake_req
);
   adcc_state_e st_r;
   adcc_state_e st_nxt;
   logic [7:0]  ctrl_r;
   logic [11:0] ans_r;
   logic [2:0]  cs_r;
   logic [2:0]  irq_r;
   logic        go_r;
   logic        go_nxt;
   logic [3:0]  step_r;
   logic [3:0]  step_nxt;
   logic [7:0]  tad_cnt_r;
   logic [9:0]  dac_r;
   logic [9:0]  res_r;
   logic        pwrdn_r;
   logic [7:0]  rdata_r;
   logic        cmp_m_r;
   logic        cmp_s_r;
   logic [11:0] pin_m_r;
   logic [11:0] pin_s_r;
   logic        irq_out_r;
   logic        wake_r;
   logic        restart;
   logic        done_evt;
   logic        sleep_abort;

   wire wr_ctrl0 = reg_wr && (reg_addr == OFS_CTRL0);
   wire wr_anslo = reg_wr && (reg_addr == OFS_ANS_LO);
   wire wr_anshi = reg_wr && (reg_addr == OFS_ANS_HI);
   wire wr_clk   = reg_wr && (reg_addr == OFS_CLK_CTRL);
   wire wr_irq   = reg_wr && (reg_addr == OFS_IRQ_CTRL);
   wire w_go     = reg_wdata[B_GO];
   wire w_en     = reg_wdata[B_EN];
   wire sw_abort = wr_ctrl0 && !w_go;
   wire off_abort = wr_ctrl0 && !w_en;
   wire rc_sel   = (cs_r[1:0] == 2'b11);
   wire just_r   = ctrl_r[B_JUST];

   // Bit period length in system clocks
   logic [7:0] tad_len;
   always_comb begin
      case (cs_r)
         CS_DIV2:  tad_len = 8'h02;
         CS_DIV8:  tad_len = 8'h08;
         CS_DIV32: tad_len = 8'h20;
         CS_DIV4:  tad_len = 8'h04;
         CS_DIV16: tad_len = 8'h10;
         CS_DIV64: tad_len = 8'h40;
         default:  tad_len = 8'(RC_TAD_CYC);
      endcase
   end
   wire tad_tick = (tad_cnt_r == 8'h00);

   // SAR step: decide previous trial bit, set next one
   wire [9:0] dec_mask  = 10'((11'h400 >> step_r));
   wire [9:0] next_mask = 10'h200 >> step_r;
   wire [9:0] dac_nxt   = (cmp_s_r ? dac_r : (dac_r & ~dec_mask)) | next_mask;

   assign sleep_abort = sleep_in && !rc_sel;

   always_comb begin
      st_nxt   = st_r;
      go_nxt   = go_r;
      step_nxt = step_r;
      restart  = 1'b0;
      done_evt = 1'b0;
      case (st_r)
         ST_IDLE: begin
            // Go only taken while enabled and powered
            if (wr_ctrl0 && w_go && w_en && !pwrdn_r && !sleep_abort) begin
               go_nxt   = 1'b1;
               restart  = 1'b1;
               step_nxt = 4'h0;
               st_nxt   = rc_sel ? ST_DELAY : ST_CONV;
            end
         end
         ST_DELAY: begin
            if (off_abort || sleep_abort) begin
               go_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end else if (sw_abort) begin
               go_nxt   = 1'b0;
               restart  = 1'b1;
               step_nxt = 4'h0;
               st_nxt   = ST_GAP;
            end else if (step_r == 4'(INSTR_CYC - 1)) begin
               restart  = 1'b1;
               step_nxt = 4'h0;
               st_nxt   = ST_CONV;
            end else begin
               step_nxt = step_r + 4'h1;
            end
         end
         ST_CONV: begin
            if (off_abort || sleep_abort) begin
               go_nxt = 1'b0;
               st_nxt = ST_IDLE;
            end else if (sw_abort) begin
               go_nxt   = 1'b0;
               restart  = 1'b1;
               step_nxt = 4'h0;
               st_nxt   = ST_GAP;
            end else if (tad_tick) begin
               if (step_r == 4'(CONV_TADS - 1)) begin
                  go_nxt   = 1'b0;
                  done_evt = 1'b1;
                  restart  = 1'b1;
                  step_nxt = 4'h0;
                  st_nxt   = ST_GAP;
               end else begin
                  step_nxt = step_r + 4'h1;
               end
            end
         end
         ST_GAP: begin
            if (off_abort) begin
               st_nxt = ST_IDLE;
            end else if (tad_tick) begin
               if (step_r == 4'(GAP_TADS - 1)) begin
                  st_nxt = ST_IDLE;
               end else begin
                  step_nxt = step_r + 4'h1;
               end
            end
         end
         default: begin
            go_nxt = 1'b0;
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_r   <= ST_IDLE;
         go_r   <= 1'b0;
         step_r <= 4'h0;
      end else begin
         st_r   <= st_nxt;
         go_r   <= go_nxt;
         step_r <= step_nxt;
      end
   end

   // Restart loads a full bit period, so eleven ticks span eleven periods
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tad_cnt_r <= 8'h00;
      end else if (restart || tad_tick) begin
         tad_cnt_r <= tad_len - 8'h01;
      end else begin
         tad_cnt_r <= tad_cnt_r - 8'h01;
      end
   end

   // Trial bits move on bit-period ticks inside a conversion and clear to zero outside one
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dac_r <= 10'h000;
      end else if (st_r != ST_CONV) begin
         dac_r <= 10'h000;
      end else if (tad_tick && !sw_abort) begin
         dac_r <= dac_nxt;
      end
   end

   // Result holds across reset and aborts
   always_ff @(posedge mclk) begin
      if (done_evt) begin
         res_r <= dac_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_r <= RST_CTRL0;
      end else if (wr_ctrl0) begin
         ctrl_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ans_r <= RST_ANS;
         cs_r  <= RST_CS;
      end else begin
         if (wr_anslo) begin
            ans_r[7:0] <= reg_wdata;
         end
         if (wr_anshi) begin
            ans_r[11:8] <= reg_wdata[3:0];
         end
         if (wr_clk) begin
            cs_r <= reg_wdata[B_CS_LO +: 3];
         end
      end
   end

   // Hardware set wins over software clear
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_r <= RST_IRQ;
      end else begin
         if (wr_irq) begin
            irq_r <= reg_wdata[2:0];
         end
         if (done_evt) begin
            irq_r[B_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pwrdn_r <= 1'b0;
      end else if (!sleep_in) begin
         pwrdn_r <= 1'b0;
      end else if (sleep_abort && (st_r != ST_IDLE)) begin
         pwrdn_r <= 1'b1;
      end else if (done_evt && !irq_r[B_IE]) begin
         pwrdn_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmp_m_r <= 1'b0;
         cmp_s_r <= 1'b0;
         pin_m_r <= 12'h000;
         pin_s_r <= 12'h000;
      end else begin
         cmp_m_r <= cmp_in;
         cmp_s_r <= cmp_m_r;
         pin_m_r <= pin_in;
         pin_s_r <= pin_m_r;
      end
   end

   wire [7:0] res_hi = just_r ? {6'h00, res_r[9:8]} : res_r[9:2];
   wire [7:0] res_lo = just_r ? res_r[7:0] : {res_r[1:0], 6'h00};
   wire [7:0] ctrl_rd = {ctrl_r[7:2], go_r, ctrl_r[B_EN]};

   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         OFS_RES_HI:   rd_mux = res_hi;
         OFS_CTRL0:    rd_mux = ctrl_rd;
         OFS_ANS_LO:   rd_mux = ans_r[7:0];
         OFS_ANS_HI:   rd_mux = {4'h0, ans_r[11:8]};
         OFS_RES_LO:   rd_mux = res_lo;
         OFS_CLK_CTRL: rd_mux = {1'b0, cs_r, 4'h0};
         OFS_IRQ_CTRL: rd_mux = {5'h00, irq_r};
         default:      rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_r   <= 8'h00;
         irq_out_r <= 1'b0;
         wake_r    <= 1'b0;
      end else begin
         rdata_r   <= reg_rd ? rd_mux : 8'h00;
         irq_out_r <= irq_r[B_FLAG] && irq_r[B_IE];
         wake_r    <= sleep_in && irq_r[B_FLAG] && irq_r[B_IE] && irq_r[B_PE];
      end
   end

   // Analog select masks digital reads and input buffer
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_pin
         assign port_read[gi] = pin_s_r[gi] && !ans_r[gi];
         assign dig_in_en[gi] = !ans_r[gi];
      end
   endgenerate

   assign reg_rdata        = rdata_r;
   assign channel_select   = ctrl_r[B_CHS_LO +: 4];
   assign reference_select = ctrl_r[B_REF];
   assign converter_power  = ctrl_r[B_EN] && !pwrdn_r;
   assign sample_en        = converter_power && (st_r == ST_IDLE);
   assign dac_code         = dac_r;
   assign conv_irq         = irq_out_r;
   assign wake_req         = wake_r;
endmodule

/* File: bench/adcc_src.sv */
// Analog source model for the converter's input side.
// Assumes a steady input level and a fixed pattern on the port pins.
module adcc_src
   import adcc_pkg::*;
(
   input  wire logic [9:0]  dac_code,
   input  wire logic [9:0]  vin,
   output logic             cmp_in,
   output logic      [11:0] pin_in
);
   // High while the input sits at or above the trial level
   assign cmp_in = (vin >= dac_code);
   assign pin_in = 12'ha5c;
endmodule

/* File: bench/adcc_ctrl_sva.sv */
// Port checker for the converter control block.
// Assumes one clock domain and the synchronous low reset.
module adcc_chk
   import adcc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        sleep_in,
   input wire logic        cmp_in,
   input wire logic [11:0] pin_in,
   input wire logic [11:0] port_read,
   input wire logic [11:0] dig_in_en,
   input wire logic [3:0]  channel_select,
   input wire logic        reference_select,
   input wire logic        converter_power,
   input wire logic        sample_en,
   input wire logic [9:0]  dac_code,
   input wire logic        conv_irq,
   input wire logic        wake_req
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire ctl_wr = reg_wr && reg_addr == OFS_CTRL0;
   a_go_start: assert property (ctl_wr && reg_wdata[1:0] == 2'b11 && sample_en && !sleep_in
      |=> (!sample_en && dac_code == 10'h000) [*2]) else $error("start not taken");
   a_ref_follow: assert property (ctl_wr |=> reference_select == $past(reg_wdata[B_REF]))
      else $error("reference select wrong");
   a_chan_follow: assert property (ctl_wr |=> channel_select == $past(reg_wdata[5:2]))
      else $error("channel select wrong");
   a_off_power: assert property (ctl_wr && !reg_wdata[B_EN] |=> !converter_power)
      else $error("power on after disable");
   a_analog_zero: assert property ((port_read & ~dig_in_en) == 12'h000) else $error("analog pin read");
   a_gap_hold: assert property ($fell(dac_code != 10'h000) |-> !sample_en [*2])
      else $error("acquisition before gap");
   a_wake_sleep: assert property (wake_req |-> conv_irq && $past(sleep_in)) else $error("wake out of sleep");
   a_reset_off: assert property (disable iff (1'b0) !nrst |=> !converter_power && !conv_irq && dac_code == 0)
      else $error("not off after reset");
   cover property ($rose(conv_irq));
   cover property ($rose(wake_req));
   cover property ($fell(sample_en));
endmodule

bind adcc_ctrl adcc_chk u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_in(sleep_in), .cmp_in(cmp_in),
   .pin_in(pin_in), .port_read(port_read), .dig_in_en(dig_in_en), .channel_select(channel_select),
   .reference_select(reference_select), .converter_power(converter_power), .sample_en(sample_en),
   .dac_code(dac_code), .conv_irq(conv_irq), .wake_req(wake_req));

/* File: bench/adc_conversion_control_tb_top.sv */
// Testbench for the converter control block.
// Assumes the analog source model on the comparator and pin inputs.
module adc_conversion_control_tb_top;
   import adcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, nrst = 0, reg_wr = 0, reg_rd = 0, sleep_in = 0, cmp_in, conv_irq, wake_req;
   logic reference_select, converter_power, sample_en;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [9:0] vin = 0, dac_code;
   logic [11:0] pin_in, port_read, dig_in_en;
   logic [3:0] channel_select;
   int err_total = 0, total_checks = 0;
   adcc_ctrl dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_in(sleep_in), .cmp_in(cmp_in), .pin_in(pin_in),
      .port_read(port_read), .dig_in_en(dig_in_en), .channel_select(channel_select),
      .reference_select(reference_select), .converter_power(converter_power), .sample_en(sample_en),
      .dac_code(dac_code), .conv_irq(conv_irq), .wake_req(wake_req));
   adcc_src u_src (.dac_code(dac_code), .vin(vin), .cmp_in(cmp_in), .pin_in(pin_in));
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk({4'h0, reg_rdata}, {4'h0, e});
   endtask
   task automatic t_regs;
      rd(OFS_CTRL0, 8'h00);
      rd(OFS_ANS_LO, 8'hff);
      rd(OFS_ANS_HI, 8'h0f);
      rd(8'h55, 8'h00);
      chk(dig_in_en, 12'h000);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_CLK_CTRL, 8'h8f | 8'(c << 4));
         rd(OFS_CLK_CTRL, 8'(c << 4));
      end
      wr(OFS_ANS_HI, 8'hf5);
      wr(OFS_ANS_LO, 8'h0f);
      rd(OFS_ANS_HI, 8'h05);
      repeat (3) @(posedge mclk);
      #1 chk(dig_in_en, 12'haf0);
      chk(port_read, 12'ha50);
      $display("t_regs done");
   endtask
   task automatic t_conv(input logic [9:0] v);
      vin <= v;
      wr(OFS_CLK_CTRL, 8'h60);
      wr(OFS_IRQ_CTRL, 8'h02);
      wr(OFS_CTRL0, 8'hb5);
      repeat (200) @(posedge mclk);
      #1 chk(channel_select, 4'hd);
      chk(reference_select, 1'b0);
      wr(OFS_CTRL0, 8'hb7);
      repeat (702) @(posedge mclk);
      rd(OFS_CTRL0, 8'hb7);
      rd(OFS_CTRL0, 8'hb5);
      chk(conv_irq, 1'b1);
      rd(OFS_IRQ_CTRL, 8'h03);
      rd(OFS_RES_HI, {6'h0, v[9:8]});
      rd(OFS_RES_LO, v[7:0]);
      wr(OFS_CTRL0, 8'h75);
      rd(OFS_RES_HI, v[9:2]);
      rd(OFS_RES_LO, {v[1:0], 6'h0});
      rd(OFS_IRQ_CTRL, 8'h03);
      chk(reference_select, 1'b1);
      $display("t_conv done");
   endtask
   task automatic t_abort;
      repeat (130) @(posedge mclk);
      wr(OFS_IRQ_CTRL, 8'h02);
      vin <= 10'h0f0;
      wr(OFS_CTRL0, 8'hb7);
      repeat (20) @(posedge mclk);
      wr(OFS_CTRL0, 8'hb5);
      repeat (2) @(posedge mclk);
      #1 chk(sample_en, 1'b0);
      repeat (125) @(posedge mclk);
      #1 chk(sample_en, 1'b0);
      @(posedge mclk);
      #1 chk(sample_en, 1'b1);
      rd(OFS_RES_HI, 8'h02);
      rd(OFS_IRQ_CTRL, 8'h02);
      wr(OFS_CTRL0, 8'hb7);
      repeat (10) @(posedge mclk);
      sleep_in <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk(converter_power, 1'b0);
      rd(OFS_CTRL0, 8'hb5);
      sleep_in <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk(converter_power, 1'b1);
      $display("t_abort done");
   endtask
   task automatic t_rc;
      int n;
      wr(OFS_CLK_CTRL, 8'h30);
      wr(OFS_IRQ_CTRL, 8'h06);
      vin <= 10'h155;
      wr(OFS_CTRL0, 8'hb7);
      sleep_in <= 1'b1;
      repeat (103) @(posedge mclk);
      #1 chk(dac_code, 10'h000);
      @(posedge mclk);
      #1 chk(dac_code, 10'h200);
      for (n = 0; n < 1500 && wake_req !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      if (n == 1500) begin
         err_total++;
      end
      rd(OFS_RES_HI, 8'h01);
      rd(OFS_CTRL0, 8'hb5);
      sleep_in <= 1'b0;
      repeat (250) @(posedge mclk);
      wr(OFS_IRQ_CTRL, 8'h04);
      wr(OFS_CTRL0, 8'hb7);
      sleep_in <= 1'b1;
      repeat (1110) @(posedge mclk);
      #1 chk(converter_power, 1'b0);
      chk(wake_req, 1'b0);
      rd(OFS_CTRL0, 8'hb5);
      sleep_in <= 1'b0;
      $display("t_rc done");
   endtask
   task automatic t_reset;
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      #1 chk(converter_power, 1'b0);
      rd(OFS_CTRL0, 8'h00);
      rd(OFS_RES_HI, 8'h55);
      rd(OFS_RES_LO, 8'h40);
      wr(OFS_CTRL0, 8'h00);
      $display("t_reset done");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      t_regs;
      t_conv(10'h2c9);
      t_abort;
      t_rc;
      t_reset;
      end_of_test;
   end
endmodule
